// >>> hw/cts_top.sv
// What this block does
// - Cascade behaviour only while enable is set
// - Role one: act as trigger master
// - Role zero: slave waits for trigger each scan
// - Master repeats trigger every programmed milliseconds
// - Slave starts scan after programmed microsecond delay
// - Pin drives on master, listens on slave
// - Function three outputs trigger, one inputs
// - Switching behaviour zero keeps light polarity
`timescale 1ns/1ps
`default_nettype none
module cts_top #(
   parameter int US_TICK_CYCLES = cts_pkg::US_TICK_CYCLES,
   parameter int US_PER_MS      = cts_pkg::US_PER_MS
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        trig_in,
   output logic             trig_out,
   output logic             trig_oe,
   output logic             scan_start,
   input  wire logic        scan_done
);

   localparam int PW = $clog2(US_TICK_CYCLES + 1);
   localparam int MW = $clog2(US_PER_MS + 1);
   localparam logic [PW-1:0] TICK_LAST = PW'(US_TICK_CYCLES - 1);
   localparam logic [MW-1:0] SUB_LAST  = MW'(US_PER_MS - 1);

   function automatic logic func_is(input cts_pkg::cts_cfg_type c,
                                    input logic [cts_pkg::FUNC_W-1:0] f);
      func_is = c.pin_func == f;
   endfunction

   cts_pkg::cts_cfg_type            cfg_q, cfg_d;
   cts_pkg::cts_state_type          state_q, state_d;
   logic [PW-1:0]                   presc_q, presc_d;
   logic [MW-1:0]                   sub_q, sub_d;
   logic [cts_pkg::MCYC_W-1:0]      ms_q, ms_d;
   logic [cts_pkg::DELAY_W-1:0]     dly_q, dly_d;
   logic [cts_pkg::SCAN_CNT_W-1:0]  scnt_q;
   logic                            trig_q, trig_d;
   logic                            prev_q;
   logic                            trig_out_q, trig_oe_q, scan_start_q;
   logic [31:0]                     prdata_q, rd_mux;
   logic                            pready_q, pslverr_q;
   logic                            start_w;

   // Role decoding
   wire master_act = cfg_q.enable && cfg_q.role == cts_pkg::ROLE_MASTER
                     && cfg_q.pin_out && func_is(cfg_q, cts_pkg::FUNC_TRIG_OUT);
   wire slave_act  = cfg_q.enable && cfg_q.role == cts_pkg::ROLE_SLAVE
                     && !cfg_q.pin_out && func_is(cfg_q, cts_pkg::FUNC_TRIG_IN);

   // Inverted switching only if software leaves light switching
   wire lvl_w    = trig_in ^ (cfg_q.pin_inv != cts_pkg::SWITCH_LIGHT);
   wire edge_w   = lvl_w && !prev_q;
   wire accept_w = slave_act && state_q == cts_pkg::S_WAIT && edge_w;

   // Microsecond tick; restarted on an accepted trigger so the delay is exact
   wire us_tick  = presc_q == TICK_LAST;
   assign presc_d = (us_tick || accept_w) ? '0 : PW'(presc_q + 1'b1);

   // Master period: microseconds within a millisecond, then milliseconds
   wire ms_tick = us_tick && sub_q == SUB_LAST;
   wire ms_last = ms_q >= cfg_q.mcyc - 16'h0001;
   wire fire    = master_act && ms_tick && ms_last && cfg_q.mcyc != '0;
   assign sub_d  = !master_act ? '0 : us_tick ? (sub_q == SUB_LAST ? '0 : MW'(sub_q + 1'b1)) : sub_q;
   assign ms_d   = !master_act ? '0 : ms_tick ? (ms_last ? '0 : ms_q + 16'h0001) : ms_q;
   // Pulse lasts one microsecond
   assign trig_d = fire || (trig_q && !us_tick && master_act);

   // Slave sequencing
   always_comb begin
      state_d = state_q;
      dly_d   = dly_q;
      start_w = 1'b0;
      case (state_q)
         cts_pkg::S_WAIT: begin
            if (accept_w) begin
               dly_d   = cfg_q.delay;
               state_d = cts_pkg::S_DELAY;
            end
         end
         cts_pkg::S_DELAY: begin
            if (dly_q == '0) begin
               start_w = 1'b1;
               state_d = cts_pkg::S_SCAN;
            end else if (us_tick) begin
               dly_d = dly_q - 24'h00_0001;
            end
         end
         cts_pkg::S_SCAN: begin
            // Edges seen here are dropped, not queued
            if (scan_done) begin
               state_d = cts_pkg::S_WAIT;
            end
         end
         default: begin
            state_d = cts_pkg::S_WAIT;
         end
      endcase
      if (!slave_act) begin
         state_d = cts_pkg::S_WAIT;
         start_w = 1'b0;
      end
   end

   // APB decode; zero wait state, answer registered in setup
   wire setup_w  = psel && !penable;
   wire write_w  = psel && penable && pready_q && pwrite;
   wire hit_ctrl = paddr == cts_pkg::ADDR_CTRL;
   wire hit_mcyc = paddr == cts_pkg::ADDR_MCYC;
   wire hit_dly  = paddr == cts_pkg::ADDR_DELAY;
   wire hit_pin  = paddr == cts_pkg::ADDR_PIN;
   wire hit_stat = paddr == cts_pkg::ADDR_STATUS;
   wire mapped   = hit_ctrl || hit_mcyc || hit_dly || hit_pin || hit_stat;

   always_comb begin
      cfg_d = cfg_q;
      if (write_w && hit_ctrl) begin
         cfg_d.enable = pwdata[cts_pkg::CTRL_EN_BIT];
         cfg_d.role   = pwdata[cts_pkg::CTRL_ROLE_BIT];
      end
      if (write_w && hit_mcyc) begin
         cfg_d.mcyc = pwdata[cts_pkg::MCYC_W-1:0];
      end
      if (write_w && hit_dly) begin
         cfg_d.delay = pwdata[cts_pkg::DELAY_W-1:0];
      end
      if (write_w && hit_pin) begin
         cfg_d.pin_out  = pwdata[cts_pkg::PIN_OUT_BIT];
         cfg_d.pin_inv  = pwdata[cts_pkg::PIN_INV_BIT];
         cfg_d.pin_func = pwdata[cts_pkg::PIN_FUNC_LSB +: cts_pkg::FUNC_W];
      end
   end

   always_comb begin
      rd_mux = '0;
      if (hit_ctrl) begin
         rd_mux[cts_pkg::CTRL_EN_BIT]   = cfg_q.enable;
         rd_mux[cts_pkg::CTRL_ROLE_BIT] = cfg_q.role;
      end
      if (hit_mcyc) begin
         rd_mux[cts_pkg::MCYC_W-1:0] = cfg_q.mcyc;
      end
      if (hit_dly) begin
         rd_mux[cts_pkg::DELAY_W-1:0] = cfg_q.delay;
      end
      if (hit_pin) begin
         rd_mux[cts_pkg::PIN_OUT_BIT]                       = cfg_q.pin_out;
         rd_mux[cts_pkg::PIN_INV_BIT]                       = cfg_q.pin_inv;
         rd_mux[cts_pkg::PIN_FUNC_LSB +: cts_pkg::FUNC_W]   = cfg_q.pin_func;
      end
      if (hit_stat) begin
         rd_mux[cts_pkg::ST_STATE_LSB +: 2]                 = state_q;
         rd_mux[cts_pkg::ST_LEVEL_BIT]                      = prev_q;
         rd_mux[cts_pkg::ST_MASTER_BIT]                     = master_act;
         rd_mux[cts_pkg::ST_SLAVE_BIT]                      = slave_act;
         rd_mux[cts_pkg::ST_TRIG_BIT]                       = trig_q;
         rd_mux[cts_pkg::ST_COUNT_LSB +: cts_pkg::SCAN_CNT_W] = scnt_q;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q   <= cts_pkg::CFG_RESET;
         state_q <= cts_pkg::S_WAIT;
         presc_q <= '0;
         sub_q   <= '0;
         ms_q    <= '0;
         dly_q   <= '0;
         trig_q  <= 1'b0;
         prev_q  <= 1'b0;
      end else begin
         cfg_q   <= cfg_d;
         state_q <= state_d;
         presc_q <= presc_d;
         sub_q   <= sub_d;
         ms_q    <= ms_d;
         dly_q   <= dly_d;
         trig_q  <= trig_d;
         prev_q  <= lvl_w;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trig_out_q   <= 1'b0;
         trig_oe_q    <= 1'b0;
         scan_start_q <= 1'b0;
         scnt_q       <= '0;
         prdata_q     <= '0;
         pready_q     <= 1'b0;
         pslverr_q    <= 1'b0;
      end else begin
         trig_oe_q    <= master_act;
         trig_out_q   <= master_act && (trig_d ^ cfg_q.pin_inv);
         scan_start_q <= start_w || fire;
         scnt_q       <= scnt_q + ((start_w || fire) ? 16'h0001 : 16'h0000);
         prdata_q     <= (setup_w && !pwrite) ? rd_mux : '0;
         pready_q     <= setup_w;
         pslverr_q    <= setup_w && !mapped;
      end
   end

   assign prdata     = prdata_q;
   assign pready     = pready_q;
   assign pslverr    = pslverr_q;
   assign trig_out   = trig_out_q;
   assign trig_oe    = trig_oe_q;
   assign scan_start = scan_start_q;

   // Helper logic for the checks below
   logic [31:0]                 gap_q, dcyc_q;
   logic                        seen_q;
   logic [cts_pkg::DELAY_W-1:0] dref_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gap_q  <= '0;
         seen_q <= 1'b0;
         dcyc_q <= '0;
         dref_q <= '0;
      end else begin
         gap_q  <= fire ? 32'h0000_0000 : gap_q + 32'h0000_0001;
         seen_q <= master_act && !write_w && (seen_q || fire);
         dcyc_q <= accept_w ? 32'h0000_0000 : dcyc_q + 32'h0000_0001;
         if (accept_w) begin
            dref_q <= cfg_q.delay;
         end
      end
   end
   wire [31:0] period_w = 32'(cfg_q.mcyc) * 32'(US_PER_MS) * 32'(US_TICK_CYCLES);
   wire [31:0] delay_w  = 32'(dref_q) * 32'(US_TICK_CYCLES);

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   disabled_quiet_a: assert property (!cfg_q.enable |=> !trig_oe_q && !scan_start_q)
      else $error("cascade output while disabled");
   master_drive_a: assert property (master_act |=> trig_oe_q)
      else $error("master does not drive trigger pin");
   slave_wait_a: assert property (state_q == cts_pkg::S_DELAY && $past(state_q) == cts_pkg::S_WAIT
                                  |-> $past(accept_w))
      else $error("slave delay began without trigger");
   trig_period_a: assert property (fire && seen_q |-> gap_q == period_w - 32'h0000_0001)
      else $error("master trigger period wrong");
   slave_delay_a: assert property (start_w |-> dcyc_q == delay_w)
      else $error("trigger to scan delay wrong");
   pin_role_a: assert property (trig_oe_q |-> $past(cfg_q.pin_out)
                                && $past(cfg_q.pin_func) == cts_pkg::FUNC_TRIG_OUT)
      else $error("pin driven without output role");
   slave_func_a: assert property (accept_w |-> func_is(cfg_q, cts_pkg::FUNC_TRIG_IN)
                                  && !cfg_q.pin_out)
      else $error("trigger accepted without input role");
   polarity_a: assert property (trig_oe_q |-> trig_out_q == (trig_q ^ $past(cfg_q.pin_inv)))
      else $error("trigger polarity wrong");
   one_scan_a: assert property (state_q == cts_pkg::S_SCAN && edge_w && !scan_done && slave_act
                                |=> state_q == cts_pkg::S_SCAN)
      else $error("retrigger during scan");
   apb_ready_a: assert property (setup_w |=> pready_q ##1 !pready_q)
      else $error("apb answer timing wrong");

   // Sequencing checks: one-cycle scan start, slave pin release, role separation, delay expiry, scan count
   start_pulse_a: assert property (scan_start_q |=> !scan_start_q)
      else $error("scan start longer than one cycle");
   slave_release_a: assert property (slave_act |=> !trig_oe_q && !trig_out_q)
      else $error("slave drives trigger pin");
   master_wait_a: assert property (master_act |=> state_q == cts_pkg::S_WAIT)
      else $error("master runs slave sequence");
   trig_only_master_a: assert property (trig_q |-> $past(master_act))
      else $error("trigger pulse outside master role");
   start_from_delay_a: assert property (start_w |-> state_q == cts_pkg::S_DELAY
                                        && dly_q == '0)
      else $error("scan started before delay expired");
   delay_hold_a: assert property (state_q == cts_pkg::S_DELAY && dly_q != '0 && slave_act
                                  |=> state_q == cts_pkg::S_DELAY)
      else $error("delay left early");
   scan_count_a: assert property (scan_start_q |-> scnt_q == $past(scnt_q) + 16'h0001)
      else $error("scan count not one per start");
   // Read data is forced to zero outside the access cycle so stale values never leak
   read_idle_a: assert property (!pready_q |-> prdata_q == '0 && !pslverr_q)
      else $error("apb outputs active outside access");

   master_fire_c: cover property (fire ##[1:1000] trig_oe_q && !trig_out_q);
   slave_scan_c: cover property (accept_w ##[1:1000] scan_start_q);
   ignored_c: cover property (state_q == cts_pkg::S_SCAN && edge_w);
   apb_err_c: cover property (pready_q && pslverr_q);
   master_period_c: cover property (fire && seen_q);

endmodule // cts_top
`default_nettype wire

// >>> hw/cts_pkg.sv
`default_nettype none
package cts_pkg;

   // Timing base
   localparam int CLK_PERIOD_NS  = 100;
   localparam int US_NS          = 1000;
   localparam int US_TICK_CYCLES = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int US_PER_MS      = 1000;

   // Register byte offsets
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_MCYC   = 8'h04;
   localparam logic [7:0] ADDR_DELAY  = 8'h08;
   localparam logic [7:0] ADDR_PIN    = 8'h0C;
   localparam logic [7:0] ADDR_STATUS = 8'h10;

   // Field positions and widths
   localparam int CTRL_EN_BIT    = 0;
   localparam int CTRL_ROLE_BIT  = 1;
   localparam int PIN_OUT_BIT    = 0;
   localparam int PIN_INV_BIT    = 1;
   localparam int PIN_FUNC_LSB   = 4;
   localparam int FUNC_W         = 4;
   localparam int MCYC_W         = 16;
   localparam int DELAY_W        = 24;
   localparam int ST_STATE_LSB   = 0;
   localparam int ST_LEVEL_BIT   = 2;
   localparam int ST_MASTER_BIT  = 3;
   localparam int ST_SLAVE_BIT   = 4;
   localparam int ST_TRIG_BIT    = 5;
   localparam int ST_COUNT_LSB   = 16;
   localparam int SCAN_CNT_W     = 16;

   // Encodings
   localparam logic              ROLE_MASTER   = 1'b1;
   localparam logic              ROLE_SLAVE    = 1'b0;
   localparam logic              SWITCH_LIGHT  = 1'b0;
   localparam logic [FUNC_W-1:0] FUNC_TRIG_OUT = 4'h3;
   localparam logic [FUNC_W-1:0] FUNC_TRIG_IN  = 4'h1;

   typedef struct packed {
      logic                 enable;
      logic                 role;
      logic [MCYC_W-1:0]    mcyc;
      logic [DELAY_W-1:0]   delay;
      logic                 pin_out;
      logic                 pin_inv;
      logic [FUNC_W-1:0]    pin_func;
   } cts_cfg_type;

   localparam cts_cfg_type CFG_RESET = '0;

   typedef enum logic [1:0] {
      S_WAIT,
      S_DELAY,
      S_SCAN
   } cts_state_type;

endpackage
`default_nettype wire

// >>> bench/cts_partner.sv
`timescale 1ns/1ps
`default_nettype none
module cts_partner #(
   parameter int PULSE_CYCLES = 2,
   parameter int SCAN_CYCLES  = 4
) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic fire,
   input  wire logic scan_start,
   output logic      trig_in,
   output logic      scan_done
);
   int pulse_q;
   int scan_q;

   // Remote master drives a one microsecond pulse; line is pulled low between pulses
   assign trig_in   = (pulse_q != 0);
   // Scan engine reports completion a fixed time after each start
   assign scan_done = (scan_q == 1);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pulse_q <= 0;
         scan_q  <= 0;
      end else begin
         pulse_q <= fire ? PULSE_CYCLES : (pulse_q != 0 ? pulse_q - 1 : 0);
         scan_q  <= scan_start ? SCAN_CYCLES : (scan_q != 0 ? scan_q - 1 : 0);
      end
   end
endmodule // cts_partner
`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam int TICK = 2;
   localparam int MS   = 3;
   logic        pclk, presetn, psel, penable, pwrite, fire;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic        pready, pslverr, trig_in, trig_out, trig_oe, scan_start, scan_done;
   int          mismatches, n_checks;
   int          cyc = 0;
   logic [31:0] rv;
   logic        re;

   cts_top #(.US_TICK_CYCLES(TICK), .US_PER_MS(MS)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .trig_in(trig_in), .trig_out(trig_out), .trig_oe(trig_oe),
      .scan_start(scan_start), .scan_done(scan_done));

   cts_partner #(.PULSE_CYCLES(TICK), .SCAN_CYCLES(4)) partner (
      .pclk(pclk), .presetn(presetn), .fire(fire), .scan_start(scan_start),
      .trig_in(trig_in), .scan_done(scan_done));

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Non-blocking so that every reader at an edge sees the same count
   always @(posedge pclk) begin
      cyc <= cyc + 1;
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rv = prdata;
      re = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic fire_once();
      @(posedge pclk);
      fire <= 1'b1;
      @(posedge pclk);
      fire <= 1'b0;
   endtask

   task automatic count_starts(input int n, output int k);
      k = 0;
      repeat (n) begin
         @(posedge pclk);
         if (scan_start === 1'b1) k++;
      end
   endtask

   task automatic reg_test();
      apb(1'b0, cts_pkg::ADDR_CTRL, 32'h0000_0000);
      chk("ctrl reset", 32'h0000_0000, rv);
      apb(1'b0, 8'h20, 32'h0000_0000);
      chk("unmapped error", 32'h0000_0001, {31'h0, re});
      apb(1'b1, cts_pkg::ADDR_DELAY, 32'hFFFF_FFFF);
      apb(1'b0, cts_pkg::ADDR_DELAY, 32'h0000_0000);
      chk("delay readback", 32'h00FF_FFFF, rv);
   endtask

   task automatic master_test();
      int t0;
      int w;
      apb(1'b1, cts_pkg::ADDR_MCYC, 32'h0000_0002);
      apb(1'b1, cts_pkg::ADDR_PIN, 32'h0000_0031);
      apb(1'b1, cts_pkg::ADDR_CTRL, 32'h0000_0003);
      w = 0;
      while (trig_out !== 1'b1 && w < 200) begin
         @(posedge pclk);
         w++;
      end
      chk("master scan start", 32'h1, {31'h0, scan_start});
      chk("master drives pin", 32'h1, {31'h0, trig_oe});
      t0 = cyc;
      w = 0;
      while (trig_out === 1'b1 && w < 200) begin
         @(posedge pclk);
         w++;
      end
      chk("pulse width", 32'(TICK), 32'(w));
      while (trig_out !== 1'b1 && w < 200) begin
         @(posedge pclk);
         w++;
      end
      chk("trigger period", 32'(2 * MS * TICK), 32'(cyc - t0));
      apb(1'b1, cts_pkg::ADDR_CTRL, 32'h0000_0002);
      count_starts(40, w);
      chk("disabled no scans", 32'h0, 32'(w));
      chk("disabled releases pin", 32'h0, {31'h0, trig_oe});
   endtask

   task automatic slave_test();
      int t0;
      int k;
      apb(1'b1, cts_pkg::ADDR_DELAY, 32'h0000_0003);
      apb(1'b1, cts_pkg::ADDR_PIN, 32'h0000_0010);
      apb(1'b1, cts_pkg::ADDR_CTRL, 32'h0000_0001);
      count_starts(30, k);
      chk("slave idle", 32'h0, 32'(k));
      chk("slave pin released", 32'h0, {31'h0, trig_oe});
      fire_once();
      t0 = cyc;
      while (scan_start !== 1'b1 && cyc - t0 < 100) @(posedge pclk);
      chk("delay window", 32'h1, 32'(cyc - t0 >= 3 * TICK && cyc - t0 <= 3 * TICK + 6));
      count_starts(30, k);
      fire_once();
      repeat (4) @(posedge pclk);
      fire_once();
      count_starts(60, k);
      chk("one scan per trigger", 32'h1, 32'(k));
      fire_once();
      count_starts(60, k);
      chk("next trigger accepted", 32'h1, 32'(k));
      // Two master triggers plus three accepted slave triggers, slave idle in wait
      apb(1'b0, cts_pkg::ADDR_STATUS, 32'h0000_0000);
      chk("status after scans", 32'h0005_0010, rv);
   endtask

   initial begin
      mismatches = 0;
      n_checks   = 0;
      presetn    = 1'b0;
      psel       = 1'b0;
      penable    = 1'b0;
      pwrite     = 1'b0;
      paddr      = 8'h00;
      pwdata     = 32'h0000_0000;
      fire       = 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      fork
         begin
            reg_test();
            master_test();
            slave_test();
         end
         begin
            // Hang guard: whole run needs well under this many cycles
            wait (cyc >= 20000);
            mismatches++;
            $display("mismatch timeout expected %0d seen %0d", 20000, cyc);
         end
      join_any
      finish_test();
   end
endmodule // testbench
`default_nettype wire
